/* logic/spcr_port.sv */
// Overview of operation
// - A one in bit 6 shifts least significant bit first, zero (default) most significant first.
// - Bit order and address stepping act only in SPI mode, never in I2C mode.
// - With bit 5 set the address rises by one after each byte of a multibyte transfer.
// - With bit 5 clear (default) the address falls by one after each byte.
// - The low nibble mirrors the high nibble and each control is the OR of the pair.
// - Bit 3 pairs with 4, bit 2 with 5, bit 1 with 6 and bit 0 with 7.
// - Writing one to bit 7 or bit 0 resets the whole device.
// - Second register bit 5 selects buffered read values instead of applied ones.
// - Writing one to second register bit 2 resets the device but keeps register contents.
module spcr_port #(
  parameter int unsigned HOLD = spcr_pkg::RST_PULSE_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic sclk,
  input  wire logic csb,
  input  wire logic sdi,
  input  wire logic i2c_mode,
  output logic      sdo_q,
  output logic      sdo_oe_n_q,
  output logic      dev_reset_q,
  output logic      core_reset_q,
  output logic      lsb_first_q,
  output logic      addr_inc_q,
  output logic      rd_buffered_q
);

  // ***************************************************************
  // Link domain state
  // ***************************************************************
  spcr_pkg::spcr_phase_t phase_q;
  logic [15:0]           shift_q;
  logic [15:0]           shift_d;
  logic [3:0]            cnt_q;
  logic                  rw_q;
  logic [14:0]           addr_q;
  logic [14:0]           addr_next;
  logic [7:0]            rd_byte_q;
  logic [7:0]            cfg_a_q;
  logic [7:0]            cfg_b_q;
  logic                  dev_tog_q;
  logic                  core_tog_q;
  logic                  i2c_s1_q;
  logic                  i2c_s2_q;
  logic                  frame_rst;
  logic                  lsb_eff;
  logic                  inc_eff;
  logic                  last_bit;
  logic                  instr_done;
  logic                  byte_done;
  logic                  wr_now;
  logic [7:0]            byte_d;
  logic                  wr_a;
  logic                  wr_b;
  logic                  soft_rst_req;
  logic [2:0]            bit_idx;

  // Raising select ends any frame at once
  assign frame_rst = rst | csb;

  // Mode strap caught in the link domain
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      i2c_s1_q <= 1'b0;
      i2c_s2_q <= 1'b0;
    end
    else
    begin
      i2c_s1_q <= i2c_mode;
      i2c_s2_q <= i2c_s1_q;
    end
  end

  // ***************************************************************
  // Effective controls
  // ***************************************************************
  // Each control is the OR of its high bit and its mirror
  assign lsb_eff = ~i2c_s2_q &
                   (cfg_a_q[spcr_pkg::A_LSB_FIRST] |
                    cfg_a_q[spcr_pkg::A_LSB_M]);
  assign inc_eff = ~i2c_s2_q &
                   (cfg_a_q[spcr_pkg::A_ADDR_ASC] |
                    cfg_a_q[spcr_pkg::A_ADDR_ASC_M]);

  // New bit enters at the end that makes the first bit land correctly
  assign shift_d = lsb_eff ? {sdi, shift_q[15:1]}
                           : {shift_q[14:0], sdi};
  assign byte_d  = lsb_eff ? shift_d[15:8] : shift_d[7:0];

  assign last_bit   = (phase_q == spcr_pkg::SPCR_INSTR)
                      ? (cnt_q == spcr_pkg::INSTR_LAST)
                      : (cnt_q[2:0] == spcr_pkg::BYTE_LAST);
  assign instr_done = (phase_q == spcr_pkg::SPCR_INSTR) & last_bit;
  assign byte_done  = (phase_q == spcr_pkg::SPCR_DATA) & last_bit;
  assign wr_now     = byte_done & ~rw_q;
  assign wr_a       = wr_now & (addr_q == spcr_pkg::CFG_A_ADDR);
  assign wr_b       = wr_now & (addr_q == spcr_pkg::CFG_B_ADDR);
  assign soft_rst_req = wr_a & (byte_d[spcr_pkg::A_SOFT_RST] |
                                byte_d[spcr_pkg::A_SOFT_RST_M]);

  // Step after each byte; the ascend bit (5 or its mirror 2) picks the direction
  assign addr_next = inc_eff ? 15'(addr_q + 15'h0001)
                             : 15'(addr_q - 15'h0001);

  // ***************************************************************
  // Read value lookup
  // ***************************************************************
  // Soft reset bits are never stored, so they read as zero
  function automatic logic [7:0] spcr_rd(input logic [14:0] a,
                                         input logic [7:0]  ca,
                                         input logic [7:0]  cb);
    logic [7:0] v;
    v = spcr_pkg::UNMAPPED_RD;
    if (a == spcr_pkg::CFG_A_ADDR)
      v = ca;
    else if (a == spcr_pkg::CFG_B_ADDR)
      v = cb;
    return v;
  endfunction : spcr_rd

  // ***************************************************************
  // Frame engine
  // ***************************************************************
  // Instruction: R/W then 15 address bits (whole word reversed, R/W last, when LSB first), then bytes until select rises
  always_ff @(posedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      phase_q   <= spcr_pkg::SPCR_INSTR;
      shift_q   <= 16'h0000;
      cnt_q     <= 4'h0;
      rw_q      <= 1'b0;
      addr_q    <= 15'h0000;
      rd_byte_q <= 8'h00;
    end
    else
    begin
      shift_q <= shift_d;
      if (instr_done)
      begin
        phase_q   <= spcr_pkg::SPCR_DATA;
        cnt_q     <= 4'h0;
        rw_q      <= shift_d[spcr_pkg::RW_POS];
        addr_q    <= shift_d[14:0];
        rd_byte_q <= spcr_rd(shift_d[14:0], cfg_a_q, cfg_b_q);
      end
      else if (byte_done)
      begin
        cnt_q     <= 4'h0;
        addr_q    <= addr_next;
        rd_byte_q <= spcr_rd(addr_next, cfg_a_q, cfg_b_q);
      end
      else
      begin
        cnt_q <= 4'(cnt_q + 4'h1);
      end
    end
  end

  // ***************************************************************
  // Output driver on the falling edge
  // ***************************************************************
  // Half a cycle of setup for the host's rising-edge sample
  assign bit_idx = lsb_eff ? cnt_q[2:0] : 3'(3'h7 - cnt_q[2:0]);

  always_ff @(negedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      sdo_q      <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end
    else
    begin
      sdo_q      <= rd_byte_q[bit_idx];
      sdo_oe_n_q <= ~((phase_q == spcr_pkg::SPCR_DATA) & rw_q);
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  // Whole-device reset also returns the map to defaults
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_a_q <= spcr_pkg::CFG_A_RESET;
      cfg_b_q <= spcr_pkg::CFG_B_RESET;
    end
    else if (soft_rst_req)
    begin
      cfg_a_q <= spcr_pkg::CFG_A_RESET;
      cfg_b_q <= spcr_pkg::CFG_B_RESET;
    end
    else
    begin
      if (wr_a)
        cfg_a_q <= byte_d & spcr_pkg::A_KEEP_MASK;
      if (wr_b)
        cfg_b_q <= byte_d & spcr_pkg::B_KEEP_MASK;
    end
  end

  // Reset requests leave as toggles; nothing is stored to clear later
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      dev_tog_q  <= 1'b0;
      core_tog_q <= 1'b0;
    end
    else
    begin
      if (soft_rst_req)
        dev_tog_q <= ~dev_tog_q;
      if (wr_b & byte_d[spcr_pkg::B_CORE_RST] & ~soft_rst_req)
        core_tog_q <= ~core_tog_q;
    end
  end

  // ***************************************************************
  // Crossings into the main clock
  // ***************************************************************
  spcr_evt_sync #(
    .HOLD    (HOLD)
  ) u_dev_rst (
    .mclk    (mclk),
    .rst     (rst),
    .tog     (dev_tog_q),
    .pulse_q (dev_reset_q)
  );

  spcr_evt_sync #(
    .HOLD    (HOLD)
  ) u_core_rst (
    .mclk    (mclk),
    .rst     (rst),
    .tog     (core_tog_q),
    .pulse_q (core_reset_q)
  );

  // Quasi-static levels, two flops each
  logic [2:0] lvl_s1_q;
  logic [2:0] lvl_s2_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lvl_s1_q <= 3'h0;
      lvl_s2_q <= 3'h0;
    end
    else
    begin
      lvl_s1_q <= {cfg_b_q[spcr_pkg::B_RD_BUF], inc_eff, lsb_eff};
      lvl_s2_q <= lvl_s1_q;
    end
  end

  assign lsb_first_q   = lvl_s2_q[0];
  assign addr_inc_q    = lvl_s2_q[1];
  assign rd_buffered_q = lvl_s2_q[2];

endmodule : spcr_port

/* shared/spcr_pkg.sv */
package spcr_pkg;

  // ***************************************************************
  // Frame layout
  // ***************************************************************
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned RW_POS     = 15;      // 1 = read
  localparam logic [3:0]  INSTR_LAST = 4'hF;
  localparam logic [2:0]  BYTE_LAST  = 3'h7;

  // ***************************************************************
  // Register offsets and reset values
  // ***************************************************************
  localparam logic [14:0] CFG_A_ADDR  = 15'h0000;
  localparam logic [14:0] CFG_B_ADDR  = 15'h0001;
  localparam logic [7:0]  CFG_A_RESET = 8'h00;
  localparam logic [7:0]  CFG_B_RESET = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;

  // Configuration A field positions (high bit and its mirror)
  localparam int unsigned A_SOFT_RST   = 7;
  localparam int unsigned A_LSB_FIRST  = 6;
  localparam int unsigned A_ADDR_ASC   = 5;
  localparam int unsigned A_ADDR_ASC_M = 2;
  localparam int unsigned A_LSB_M      = 1;
  localparam int unsigned A_SOFT_RST_M = 0;
  localparam logic [7:0]  A_KEEP_MASK  = 8'h66;  // Stored bits 6,5,2,1

  // Configuration B field positions
  localparam int unsigned B_RD_BUF     = 5;
  localparam int unsigned B_CORE_RST   = 2;
  localparam logic [7:0]  B_KEEP_MASK  = 8'h20;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned MCLK_HZ      = 25_000_000;
  localparam int unsigned RST_PULSE_NS = 200;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

  // ***************************************************************
  // Frame phases
  // ***************************************************************
  typedef enum logic [0:0] {
    SPCR_INSTR = 1'b0,
    SPCR_DATA  = 1'b1
  } spcr_phase_t;

endpackage : spcr_pkg

/* logic/spcr_evt_sync.sv */
module spcr_evt_sync #(
  parameter int unsigned HOLD = spcr_pkg::RST_PULSE_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tog,
  output logic      pulse_q
);

  // ***************************************************************
  // Toggle crossing and pulse stretch
  // ***************************************************************
  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic [7:0] cnt_q;

  // First stage is read only by the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= tog;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A fresh event restarts the hold count
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 8'h00;
      pulse_q <= 1'b0;
    end
    else if (s2_q != s3_q)
    begin
      cnt_q   <= 8'(HOLD - 1);
      pulse_q <= 1'b1;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
    end
    else
    begin
      pulse_q <= 1'b0;
    end
  end

endmodule : spcr_evt_sync

/* test/spcr_host.sv */
module spcr_host (
  output logic      sclk,
  output logic      csb,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lsb;  // Bit order the host frames in
  // ***************************************************************
  // Idle: clock stands low, chip deselected
  // ***************************************************************
  initial
  begin
    sclk = 1'b0;
    csb  = 1'b1;
    sdi  = 1'b0;
    lsb  = 1'b0;
  end
  // One bit: data set while sclk low, reply caught at the rise
  task automatic shift(input logic b, output logic r);
    sdi = b;
    #7.5 sclk = 1'b1;
    r = sdo;
    #7.5 sclk = 1'b0;
  endtask : shift
  // Whole frame; the clock runs only inside it
  task automatic frame(input logic rw, input logic [14:0] a, input logic [15:0] wd,
                       input int nb, output logic [15:0] rd);
    logic [15:0] w;
    logic        r;
    w  = {rw, a};
    rd = 16'h0000;
    #3 csb = 1'b0;
    for (int i = 0; i < 16; i++)
      shift(w[lsb ? i : 15 - i], r);
    for (int i = 0; i < 8 * nb; i++)
    begin
      shift(wd[15 - 8 * (i / 8) - (lsb ? 7 - i % 8 : i % 8)], r);
      rd[15 - 8 * (i / 8) - (lsb ? 7 - i % 8 : i % 8)] = r;
    end
    #7.5 csb = 1'b1;
    sdi = ~sdi;  // Released line must not keep the last bit
  endtask : frame
endmodule : spcr_host

/* test/spcr_port_assertions.sv */
module spcr_port_chk #(
  parameter int unsigned HOLD = spcr_pkg::RST_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdi,
  input wire logic i2c_mode,
  input wire logic sdo_q,
  input wire logic sdo_oe_n_q,
  input wire logic dev_reset_q,
  input wire logic core_reset_q,
  input wire logic lsb_first_q,
  input wire logic addr_inc_q,
  input wire logic rd_buffered_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  int unsigned dev_n_q;
  int unsigned core_n_q;
  // Cycles the device reset pulse has stood high
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dev_n_q <= 0;
    else
      dev_n_q <= dev_reset_q ? dev_n_q + 1 : 0;
  end
  // Same for the register-keeping reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      core_n_q <= 0;
    else
      core_n_q <= core_reset_q ? core_n_q + 1 : 0;
  end
  a_dev_pulse_len: assert property ($fell(dev_reset_q) |-> dev_n_q == HOLD)
    else $error("device reset pulse length wrong");
  a_core_pulse_len: assert property ($fell(core_reset_q) |-> core_n_q == HOLD)
    else $error("core reset pulse length wrong");
  a_reset_quiet: assert property ($fell(rst) |-> !dev_reset_q && !core_reset_q
    && !lsb_first_q && !addr_inc_q && sdo_oe_n_q)
    else $error("outputs not at defaults after reset");
  a_soft_clears: assert property ($rose(dev_reset_q) |-> ##[0:4]
    (!lsb_first_q && !addr_inc_q && !rd_buffered_q))
    else $error("controls not cleared by soft reset");
  a_core_keeps: assert property ($rose(core_reset_q) |=>
    $stable(lsb_first_q) && $stable(addr_inc_q) && $stable(rd_buffered_q))
    else $error("core reset disturbed controls");
  a_oe_idle_high: assert property (csb && $past(csb) |-> sdo_oe_n_q)
    else $error("output driven while deselected");
  a_resets_apart: assert property (!(dev_reset_q && core_reset_q))
    else $error("both resets at once");
  a_dev_no_retrig: assert property ($fell(dev_reset_q) |=> !dev_reset_q)
    else $error("device reset retriggered");
endmodule : spcr_port_chk
bind spcr_port spcr_port_chk #(.HOLD(HOLD)) i_chk (
  .mclk(mclk), .rst(rst), .sclk(sclk), .csb(csb), .sdi(sdi), .i2c_mode(i2c_mode),
  .sdo_q(sdo_q), .sdo_oe_n_q(sdo_oe_n_q), .dev_reset_q(dev_reset_q),
  .core_reset_q(core_reset_q), .lsb_first_q(lsb_first_q), .addr_inc_q(addr_inc_q),
  .rd_buffered_q(rd_buffered_q));

/* test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HOLD = 2;  // Short pulse keeps the run brief
  logic mclk, rst, i2c_mode, sclk, csb, sdi, sdo_q, sdo_oe_n_q;
  logic dev_reset_q, core_reset_q, lsb_first_q, addr_inc_q, rd_buffered_q;
  int   n_mismatch = 0;
  int   n_checks = 0;
  int   n_cyc = 0;
  logic [7:0] corner [4] = '{8'h40, 8'h02, 8'h04, 8'h18};
  spcr_host i_host (.sclk(sclk), .csb(csb), .sdi(sdi), .sdo(sdo_q));
  spcr_port #(.HOLD(HOLD)) i_dut (
    .mclk(mclk), .rst(rst), .sclk(sclk), .csb(csb), .sdi(sdi), .i2c_mode(i2c_mode),
    .sdo_q(sdo_q), .sdo_oe_n_q(sdo_oe_n_q), .dev_reset_q(dev_reset_q),
    .core_reset_q(core_reset_q), .lsb_first_q(lsb_first_q), .addr_inc_q(addr_inc_q),
    .rd_buffered_q(rd_buffered_q));
  // ***************************************************************
  // Clock, watchdog and helpers
  // ***************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Cut a hang short
  always @(posedge mclk)
  begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  // Stored value: soft reset bits are never kept
  function automatic logic [7:0] exp_a(input logic [7:0] v);
    return (v[7] | v[0]) ? 8'h00 : v & spcr_pkg::A_KEEP_MASK;
  endfunction : exp_a
  // Second byte: address 1 when stepping up, unmapped 0x7FFF when down
  function automatic logic [7:0] exp_next(input logic [7:0] a, input logic [7:0] b);
    return (a[5] | a[2]) ? b : 8'h00;
  endfunction : exp_next
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    logic [15:0] r;
    i_host.frame(1'b0, a, {v, 8'h00}, 1, r);
    repeat (10) @(posedge mclk);  // Levels cross in about two cycles
  endtask : wr
  // Length of the next pulse, waited for under a bound
  task automatic pulse_len(input logic core, input string nm);
    int n;
    int t;
    n = 0;
    t = 0;
    while (t < 50 && (core ? core_reset_q : dev_reset_q) !== 1'b1)
    begin
      @(posedge mclk);
      #1 t++;
    end
    while (n < 50 && (core ? core_reset_q : dev_reset_q) === 1'b1)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk(nm, 16'(HOLD), 16'(n));
  endtask : pulse_len
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    logic [15:0] r;
    logic [7:0]  v;
    logic [7:0]  a_last;
    int          seed;
    seed = 53;
    rst = 1'b1;
    i2c_mode = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk("levels", 16'h0000, {12'h000, dev_reset_q, core_reset_q, lsb_first_q, addr_inc_q});
    wr(15'h0001, 8'h20);
    chk("buffered", 16'h0001, {15'h0, rd_buffered_q});
    i_host.frame(1'b1, 15'h0001, 16'h0000, 2, r);
    chk("step down", 16'h2000, r);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      v = (i < 4) ? corner[i] : v & 8'h7E;
      a_last = exp_a(v);
      wr(15'h0000, v);
      i_host.lsb = v[6] | v[1];
      chk("order", {14'h0, v[6] | v[1], v[5] | v[2]}, {14'h0, lsb_first_q, addr_inc_q});
      i_host.frame(1'b1, 15'h0000, 16'h0000, 2, r);
      chk("readback", {a_last, exp_next(v, 8'h20)}, r);
    end
    i_host.frame(1'b0, 15'h0001, 16'h2400, 1, r);
    pulse_len(1'b1, "core pulse");
    i_host.frame(1'b1, 15'h0000, 16'h0000, 2, r);
    chk("kept", {a_last, exp_next(a_last, 8'h20)}, r);
    i_host.frame(1'b0, 15'h0000, 16'h0100, 1, r);
    pulse_len(1'b0, "mirror reset");
    i_host.lsb = 1'b0;
    i_host.frame(1'b1, 15'h0001, 16'h0000, 2, r);
    chk("cleared", 16'h0000, r);
    i2c_mode <= 1'b1;
    @(posedge mclk);
    wr(15'h0000, 8'h66);
    chk("i2c levels", 16'h0000, {14'h0, lsb_first_q, addr_inc_q});
    i_host.frame(1'b1, 15'h0000, 16'h0000, 2, r);
    chk("i2c read", 16'h6600, r);
    i_host.frame(1'b0, 15'h0000, 16'h8000, 1, r);
    pulse_len(1'b0, "high reset");
    results();
  end
endmodule : testbench
